//--- logic/lin_params.svh
// register map, field positions, reset values and timing counts of the lin extension
`ifndef LIN_PARAMS_SVH
`define LIN_PARAMS_SVH
`define LIN_A_STAT 8'h00
`define LIN_A_CTRL 8'h04
`define LIN_A_DATA 8'h08
`define LIN_A_MANT 8'h0C
`define LIN_A_FRAC 8'h10
`define LIN_A_BRR 8'h14
`define LIN_A_HLEN 8'h18
`define LIN_C_LINE 0
`define LIN_C_M 1
`define LIN_C_SLV 2
`define LIN_C_SBK 3
`define LIN_C_HDM 4
`define LIN_C_HIE 5
`define LIN_C_RIE 6
`define LIN_C_ASE 7
`define LIN_C_PCE 8
`define LIN_C_LSF 9
`define LIN_C_HDF 10
`define LIN_S_RX_DATA_FULL 0
`define LIN_S_TX_DATA_EMPTY 1
`define LIN_S_FE 2
`define LIN_S_OR 3
`define LIN_S_PE 4
`define LIN_S_LHE 5
`define LIN_RST_STAT 6'h02
`define LIN_RST_MANT 8'h01
`define LIN_RST_BRR 8'h01
`define LIN_OVS 16
`define LIN_HDR_BITS 57
`define LIN_BRK_MIN_BITS 4'hB
`define LIN_BRK_TX_BITS 4'hE
`define LIN_CHAR_BITS 4'hA
`define LIN_SYNC_CHAR 8'h55
`define LIN_SYNC_LAST_EDGE 3'h4
`endif

//--- logic/lin_pkg.sv
// types of the lin extension: state codes and the state record
`default_nettype none
package lin_pkg;
  typedef enum logic [3:0] {
    HDR_HUNT = 4'b0001,
    HDR_SYNC = 4'b0010,
    HDR_IDENT = 4'b0100,
    HDR_BLOCK = 4'b1000
  } lin_hdr_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_DATA = 3'b010,
    RX_BRK = 3'b100
  } lin_rx_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [10:0] ctrl;
    logic [5:0] stat;
    logic stat_seen;
    logic [7:0] rdr;
    logic [7:0] tdr;
    logic [7:0] mant;
    logic [3:0] frac;
    logic [7:0] brr;
    logic [12:0] acc;
    lin_rx_t rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_d;
    logic tx_busy;
    logic [3:0] tx_ph;
    logic [3:0] tx_cnt;
    logic [13:0] tx_sh;
    logic brk_pend;
    logic txd;
    lin_hdr_t hdr;
    logic tout_on;
    logic [9:0] tout;
    logic [2:0] edges;
    logic [14:0] meas;
    logic [14:0] iv;
    logic irq;
  } lin_state_t;
endpackage : lin_pkg
`default_nettype wire

//--- logic/lin_serial.sv
// lin mode serial extension: ahb-lite registers, baud, rx/tx, slave header logic
`timescale 1ns/1ps
`default_nettype none
`include "lin_params.svh"
module lin_serial (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd,
  output logic txd,
  input wire logic [1:0] cpu_mask,
  output logic irq
);
  localparam logic [9:0] TOUT_LIM = 10'(`LIN_HDR_BITS * `LIN_OVS);
  lin_pkg::lin_state_t s, n;
  logic slv, ase, hdm, tick, addr_ok, rd_stat, rd_data, lsf_clr, sw_div;
  logic ch_ev, brk_ev, fe_ev, ovf_ev, tout_ev, dlv, par_ev;
  logic [11:0] div12;
  logic [12:0] acc_sum;
  logic [14:0] exp_meas, min_iv;

  function automatic logic id_par_bad(input logic [7:0] d);
    id_par_bad = (d[6] != (d[0] ^ d[1] ^ d[2] ^ d[4])) ||
                 (d[7] != ~(d[1] ^ d[3] ^ d[4] ^ d[5]));
  endfunction : id_par_bad

  function automatic logic dev_bad(input logic [14:0] m, input logic [14:0] e);
    logic [14:0] diff;
    diff = (m > e) ? m - e : e - m;
    dev_bad = diff > (e >> 3) + (e >> 5);
  endfunction : dev_bad

  assign slv = s.ctrl[`LIN_C_LINE] & s.ctrl[`LIN_C_SLV];
  assign ase = s.ctrl[`LIN_C_ASE];
  assign hdm = s.ctrl[`LIN_C_HDM];
  // slave uses the fractional lin divider, master the plain prescaler
  assign div12 = slv ? {s.mant, s.frac} : {s.brr, 4'h0};
  assign acc_sum = s.acc + 13'h0010;
  assign tick = acc_sum >= {1'b0, div12};
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_stat = addr_ok & ~hwrite & (haddr[7:0] == `LIN_A_STAT);
  assign rd_data = addr_ok & ~hwrite & (haddr[7:0] == `LIN_A_DATA);
  assign exp_meas = {div12, 3'h0};
  assign min_iv = 15'({div12, 1'b0}) - 15'(div12 >> 1);
  assign sw_div = s.wr_pend & ((s.wr_addr == `LIN_A_MANT) | (s.wr_addr == `LIN_A_FRAC));

  always_comb
  begin
    n = s;
    ch_ev = 1'b0;
    brk_ev = 1'b0;
    fe_ev = 1'b0;
    ovf_ev = 1'b0;
    tout_ev = 1'b0;
    dlv = 1'b0;
    par_ev = 1'b0;
    // data phase of a write
    if (s.wr_pend)
    begin
      case (s.wr_addr)
        `LIN_A_CTRL: n.ctrl = hwdata[10:0];
        `LIN_A_DATA:
        begin
          n.tdr = hwdata[7:0];
          n.stat[`LIN_S_TX_DATA_EMPTY] = 1'b0;
        end
        `LIN_A_MANT: n.mant = hwdata[7:0];
        `LIN_A_FRAC: n.frac = hwdata[3:0];
        `LIN_A_BRR: n.brr = hwdata[7:0];
        default: ;
      endcase
    end
    lsf_clr = s.ctrl[`LIN_C_LSF] & ~n.ctrl[`LIN_C_LSF];
    // address phase; zero wait states, always okay
    n.hready = 1'b1;
    n.hresp = 1'b0;
    n.wr_pend = addr_ok & hwrite;
    n.wr_addr = haddr[7:0];
    n.hrdata = 32'h0000_0000;
    if (addr_ok & ~hwrite)
    begin
      case (haddr[7:0])
        `LIN_A_STAT: n.hrdata = {26'h0, s.stat};
        `LIN_A_CTRL: n.hrdata = {21'h0, s.ctrl};
        `LIN_A_DATA: n.hrdata = {24'h0, s.rdr};
        `LIN_A_MANT: n.hrdata = {24'h0, s.mant};
        `LIN_A_FRAC: n.hrdata = {28'h0, s.frac};
        `LIN_A_BRR: n.hrdata = {24'h0, s.brr};
        `LIN_A_HLEN: n.hrdata = {22'h0, s.tout};
        default: ;
      endcase
    end
    if (rd_stat)
      n.stat_seen = 1'b1;
    if (rd_data & s.stat_seen)
    begin
      // clears go first so that a same-cycle event still sets its flag
      n.stat[`LIN_S_RX_DATA_FULL] = 1'b0;
      n.stat[`LIN_S_FE] = 1'b0;
      n.stat[`LIN_S_OR] = 1'b0;
      n.stat[`LIN_S_PE] = 1'b0;
      n.stat[`LIN_S_LHE] = 1'b0;
      n.stat_seen = 1'b0;
    end
    // 16x oversampling tick, fractional accumulator
    n.acc = tick ? acc_sum - {1'b0, div12} : acc_sum;
    n.rx_d = rxd;
    // break request only in master mode
    // mode taken from the same write, so a joint slave and break write sends nothing
    if (n.ctrl[`LIN_C_LINE] & ~n.ctrl[`LIN_C_SLV] & n.ctrl[`LIN_C_SBK] & ~s.ctrl[`LIN_C_SBK])
      n.brk_pend = 1'b1;
    // transmitter
    if (tick)
    begin
      if (!s.tx_busy)
      begin
        n.tx_ph = 4'h0;
        if (s.brk_pend)
        begin
          n.tx_busy = 1'b1;
          n.tx_sh = 14'h2000;
          n.tx_cnt = `LIN_BRK_TX_BITS;
          n.brk_pend = 1'b0;
        end
        else if (!s.stat[`LIN_S_TX_DATA_EMPTY] && !(s.wr_pend && s.wr_addr == `LIN_A_DATA))
        begin
          n.tx_busy = 1'b1;
          n.tx_sh = {4'hF, 1'b1, s.tdr, 1'b0};
          n.tx_cnt = `LIN_CHAR_BITS;
          n.stat[`LIN_S_TX_DATA_EMPTY] = 1'b1;
        end
      end
      else
      begin
        n.tx_ph = s.tx_ph + 4'h1;
        if (s.tx_ph == 4'hF)
        begin
          n.tx_sh = {1'b1, s.tx_sh[13:1]};
          n.tx_cnt = s.tx_cnt - 4'h1;
          if (s.tx_cnt == 4'h1)
            n.tx_busy = 1'b0;
        end
      end
    end
    n.txd = n.tx_busy ? n.tx_sh[0] : 1'b1;
    // receiver, stopped while the synch field is measured
    // idle looks at every clock: a start edge between two ticks would be lost
    if ((tick || s.rx_st == lin_pkg::RX_IDLE) &&
        !(slv && ase && s.hdr == lin_pkg::HDR_SYNC))
    begin
      unique case (s.rx_st)
        lin_pkg::RX_IDLE:
        begin
          // start only on a falling edge, so a low level mid-synch is no start
          if (s.rx_d & ~rxd)
          begin
            n.rx_st = lin_pkg::RX_DATA;
            n.rx_ph = 4'h0;
            n.rx_bit = 4'h0;
          end
        end
        lin_pkg::RX_DATA:
        begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (s.rx_ph == 4'h8)
          begin
            n.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == 4'h0 && rxd)
              n.rx_st = lin_pkg::RX_IDLE;
            else if (s.rx_bit == `LIN_CHAR_BITS - 4'h1)
            begin
              if (rxd)
              begin
                ch_ev = 1'b1;
                n.rx_st = lin_pkg::RX_IDLE;
              end
              else if (s.rx_sh == 8'h00)
                n.rx_st = lin_pkg::RX_BRK;
              else
              begin
                fe_ev = 1'b1;
                n.rx_st = lin_pkg::RX_IDLE;
              end
            end
            else if (s.rx_bit != 4'h0)
              n.rx_sh = {rxd, s.rx_sh[7:1]};
          end
        end
        lin_pkg::RX_BRK:
        begin
          n.rx_ph = s.rx_ph + 4'h1;
          if (rxd)
          begin
            // fewer than 11 low bits is a framing error, not a break
            brk_ev = s.rx_bit >= `LIN_BRK_MIN_BITS;
            fe_ev = s.rx_bit < `LIN_BRK_MIN_BITS;
            n.rx_st = lin_pkg::RX_IDLE;
          end
          else if (s.rx_ph == 4'h8 && s.rx_bit != 4'hF)
            n.rx_bit = s.rx_bit + 4'h1;
        end
      endcase
    end
    // header handling
    if (!slv)
    begin
      n.hdr = lin_pkg::HDR_HUNT;
      n.tout_on = 1'b0;
      dlv = ch_ev;
      if (fe_ev)
        n.stat[`LIN_S_FE] = 1'b1;
    end
    else
    begin
      if (fe_ev)
      begin
        n.stat[`LIN_S_FE] = 1'b1;
        if (s.hdr == lin_pkg::HDR_SYNC || s.hdr == lin_pkg::HDR_IDENT)
        begin
          n.stat[`LIN_S_LHE] = 1'b1;
          n.tout_on = 1'b0;
          n.hdr = lin_pkg::HDR_HUNT;
        end
      end
      unique case (s.hdr)
        lin_pkg::HDR_HUNT: dlv = ch_ev;
        lin_pkg::HDR_SYNC:
        begin
          if (ase)
          begin
            if (s.edges != 3'h0)
            begin
              n.meas = s.meas + 15'h0001;
              n.iv = s.iv + 15'h0001;
              if (&s.meas)
                ovf_ev = 1'b1;
            end
            if (s.rx_d & ~rxd & ~ovf_ev)
            begin
              n.edges = s.edges + 3'h1;
              n.iv = 15'h0000;
              if (s.edges != 3'h0 && s.iv < min_iv)
                ovf_ev = 1'b1;
              else if (s.edges == `LIN_SYNC_LAST_EDGE)
              begin
                // interval counted edge to edge, closing clock included
                if (dev_bad(n.meas, exp_meas))
                begin
                  n.stat[`LIN_S_LHE] = 1'b1;
                  n.tout_on = 1'b0;
                  n.hdr = lin_pkg::HDR_HUNT;
                end
                else
                begin
                  n.hdr = lin_pkg::HDR_IDENT;
                  // a software write of the divider wins over the measured value
                  if (!sw_div)
                    {n.mant, n.frac} = n.meas[14:3];
                end
              end
            end
            if (ovf_ev)
            begin
              n.stat[`LIN_S_LHE] = 1'b1;
              n.ctrl[`LIN_C_LSF] = 1'b1;
              n.tout_on = 1'b0;
              n.hdr = lin_pkg::HDR_BLOCK;
            end
          end
          else if (ch_ev)
          begin
            dlv = ~hdm;
            if (s.rx_sh != `LIN_SYNC_CHAR)
            begin
              n.stat[`LIN_S_LHE] = 1'b1;
              n.tout_on = 1'b0;
              n.hdr = lin_pkg::HDR_HUNT;
            end
            else
              n.hdr = lin_pkg::HDR_IDENT;
          end
        end
        lin_pkg::HDR_IDENT:
        begin
          if (ch_ev)
          begin
            dlv = 1'b1;
            if (hdm)
              n.ctrl[`LIN_C_HDF] = 1'b1;
            if (s.ctrl[`LIN_C_PCE] && id_par_bad(s.rx_sh))
            begin
              par_ev = 1'b1;
              n.stat[`LIN_S_PE] = 1'b1;
            end
            n.tout_on = 1'b0;
            n.hdr = lin_pkg::HDR_HUNT;
          end
        end
        lin_pkg::HDR_BLOCK:
        begin
          if (!n.ctrl[`LIN_C_LSF])
            n.hdr = lin_pkg::HDR_HUNT;
        end
      endcase
      if (s.tout_on & tick)
      begin
        n.tout = s.tout + 10'h001;
        if (s.tout == TOUT_LIM - 10'h001)
        begin
          tout_ev = 1'b1;
          n.stat[`LIN_S_LHE] = 1'b1;
          n.tout_on = 1'b0;
          if (s.hdr == lin_pkg::HDR_SYNC && ase)
          begin
            n.ctrl[`LIN_C_LSF] = 1'b1;
            n.hdr = lin_pkg::HDR_BLOCK;
          end
          else
            n.hdr = lin_pkg::HDR_HUNT;
        end
      end
      if (lsf_clr && s.hdr == lin_pkg::HDR_SYNC)
      begin
        n.tout_on = 1'b0;
        n.hdr = lin_pkg::HDR_HUNT;
      end
      if (brk_ev && s.hdr != lin_pkg::HDR_BLOCK)
      begin
        n.hdr = lin_pkg::HDR_SYNC;
        n.tout = 10'h000;
        n.tout_on = hdm | ase;
        n.edges = 3'h0;
        n.meas = 15'h0000;
        if (!hdm)
        begin
          n.rdr = 8'h00;
          n.stat[`LIN_S_RX_DATA_FULL] = 1'b1;
          n.ctrl[`LIN_C_HDF] = 1'b1;
        end
      end
    end
    if (dlv)
    begin
      if (n.stat[`LIN_S_RX_DATA_FULL])
      begin
        n.stat[`LIN_S_OR] = 1'b1;
        if (slv && s.hdr != lin_pkg::HDR_HUNT)
          n.stat[`LIN_S_LHE] = 1'b1;
      end
      n.rdr = s.rx_sh;
      n.stat[`LIN_S_RX_DATA_FULL] = 1'b1;
    end
    n.irq = (cpu_mask == 2'h0) &
            ((n.ctrl[`LIN_C_HIE] & n.ctrl[`LIN_C_HDF]) |
             (n.ctrl[`LIN_C_RIE] & (n.stat[`LIN_S_LHE] | n.stat[`LIN_S_RX_DATA_FULL])));
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
      s.hready <= 1'b1;
      s.stat <= `LIN_RST_STAT;
      s.mant <= `LIN_RST_MANT;
      s.brr <= `LIN_RST_BRR;
      s.rx_st <= lin_pkg::RX_IDLE;
      s.hdr <= lin_pkg::HDR_HUNT;
      s.rx_d <= 1'b1;
      s.txd <= 1'b1;
    end
    else
      s <= n;
  end

  assign hrdata = s.hrdata;
  assign hreadyout = s.hready;
  assign hresp = s.hresp;
  assign txd = s.txd;
  assign irq = s.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_break_flags: assert property (brk_ev && slv && !hdm && s.hdr != lin_pkg::HDR_BLOCK |=>
    s.stat[`LIN_S_RX_DATA_FULL] && s.rdr == 8'h00 && s.ctrl[`LIN_C_HDF])
    else $error("break did not set data full with zero data");
  a_slave_nobreak: assert property (slv && !s.brk_pend |=> !s.brk_pend)
    else $error("send break took effect in slave mode");
  sequence brk_start_s;
    s.brk_pend && !s.tx_busy && tick;
  endsequence
  a_tx_break: assert property (brk_start_s |=> s.tx_busy && s.tx_cnt == 4'hE ##1 !s.txd)
    else $error("break frame not started with 14 bit slots");
  a_tout_fire: assert property (slv && s.tout_on && tick && s.tout == TOUT_LIM - 10'h001 |=>
    s.stat[`LIN_S_LHE] && !s.tout_on)
    else $error("header timeout not flagged at 57 bit times");
  a_tout_early: assert property (s.tout_on |-> s.tout < TOUT_LIM)
    else $error("header timeout counter ran past its limit");
  a_ident_parity: assert property (slv && s.hdr == lin_pkg::HDR_IDENT && ch_ev &&
    s.ctrl[`LIN_C_PCE] && id_par_bad(s.rx_sh) |=> s.stat[`LIN_S_PE])
    else $error("identifier parity error missed");
  a_irq_header: assert property (cpu_mask == 2'h0 && s.ctrl[`LIN_C_HIE] &&
    s.ctrl[`LIN_C_HDF] && !s.wr_pend |=> s.irq)
    else $error("header interrupt not requested");
  a_lhe_clear: assert property ($fell(s.stat[`LIN_S_LHE]) |-> $past(rd_data) && $past(s.stat_seen))
    else $error("header error cleared without status then data read");
  a_ovf_lock: assert property (ovf_ev |=> s.ctrl[`LIN_C_LSF] && s.stat[`LIN_S_LHE] &&
    s.hdr == lin_pkg::HDR_BLOCK)
    else $error("synch fault did not lock");
  a_ase_quiet: assert property (slv && ase && s.hdr == lin_pkg::HDR_SYNC |-> !ch_ev)
    else $error("character delivered during synch measurement");
endmodule : lin_serial
`default_nettype wire

//--- tb/lin_node.sv
// lin bus node model: drives the receive line, watches the transmit line
`timescale 1ns/1ps
`default_nettype none
module lin_node #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk,
  output logic rxd_line,
  input wire logic txd_line
);
  // recessive level between frames, the bus has a pull-up
  initial rxd_line = 1'b1;
  // 8n1 lsb first; a low stop makes a framing fault on purpose
  task automatic send_char(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd_line <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : send_char
  // master header start: long dominant field then one recessive bit
  task automatic send_break(input int nbits);
    rxd_line <= 1'b0;
    repeat (nbits * BIT_CLKS) @(posedge clk);
    rxd_line <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : send_break
  task automatic measure_low(output int n);
    n = 0;
    while (txd_line !== 1'b0) @(posedge clk);
    while (txd_line === 1'b0)
    begin
      @(posedge clk);
      n++;
    end
  endtask : measure_low
  // samples mid-bit, so a small baud slip still reads clean
  task automatic recv_char(output logic [7:0] b);
    while (txd_line !== 1'b0) @(posedge clk);
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk);
      b[i] = txd_line;
    end
    repeat (BIT_CLKS) @(posedge clk);
  endtask : recv_char
  task automatic count_low(input int clks, output int n);
    n = 0;
    repeat (clks)
    begin
      @(posedge clk);
      if (txd_line !== 1'b1)
        n++;
    end
  endtask : count_low
endmodule : lin_node
`default_nettype wire

//--- tb/lin_mode_serial_extension_tb_top.sv
// testbench of the lin extension: register bus tasks and header scenarios
`timescale 1ns/1ps
`default_nettype none
`include "lin_params.svh"
module lin_mode_serial_extension_tb_top;
  localparam int BITC = 64;
  localparam logic [7:0] RA [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18};
  localparam logic [31:0] RE [6] = '{32'h2, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rxd;
  logic txd;
  logic [1:0] cpu_mask = 2'h3;
  logic irq;
  int fail_count = 0;
  int check_count = 0;
  int n;
  logic [31:0] rv;
  logic [31:0] cfg;
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] idb;
  always #2.5 clk = ~clk;
  lin_serial lin_serial_inst (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd),
    .cpu_mask(cpu_mask), .irq(irq));
  lin_node #(.BIT_CLKS(BITC)) lin_node_inst (.clk(clk), .rxd_line(rxd), .txd_line(txd));
  function automatic logic [7:0] lin_id(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : lin_id
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    d = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
  endtask : wr
  task automatic waitb(input int nb);
    repeat (nb * BITC) @(posedge clk);
  endtask : waitb
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // a hung handshake or header wait ends here instead of running forever
  initial
  begin
    #400000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (RA[i])
    begin
      rd(RA[i], rv);
      check(rv, RE[i]);
    end
    // master: break length then synch and identifier on the wire
    wr(`LIN_A_CTRL, 32'h1 << `LIN_C_LINE);
    wr(`LIN_A_BRR, 32'h4);
    wr(`LIN_A_CTRL, (32'h1 << `LIN_C_LINE) | (32'h1 << `LIN_C_SBK));
    lin_node_inst.measure_low(n);
    check(32'(n >= 13 * BITC - 8 && n <= 13 * BITC + 8), 32'h1);
    fork
      begin
        lin_node_inst.recv_char(b0);
        lin_node_inst.recv_char(b1);
      end
      begin
        wr(`LIN_A_CTRL, 32'h1 << `LIN_C_LINE);
        wr(`LIN_A_DATA, 32'h55);
        rv = 32'h0;
        while (rv[`LIN_S_TX_DATA_EMPTY] !== 1'b1) rd(`LIN_A_STAT, rv);
        wr(`LIN_A_DATA, {24'h0, lin_id(6'h1A)});
      end
    join
    check({24'h0, b0}, 32'h55);
    check({24'h0, b1}, {24'h0, lin_id(6'h1A)});
    // slave: break request must leave the line recessive
    cfg = (32'h1 << `LIN_C_LINE) | (32'h1 << `LIN_C_SLV);
    wr(`LIN_A_CTRL, cfg | (32'h1 << `LIN_C_SBK));
    lin_node_inst.count_low(20 * BITC, n);
    check(32'(n), 32'h0);
    cfg = cfg | (32'h1 << `LIN_C_HIE);
    wr(`LIN_A_CTRL, cfg);
    wr(`LIN_A_MANT, 32'h4);
    wr(`LIN_A_FRAC, 32'h0);
    cpu_mask <= 2'h1;
    lin_node_inst.send_break(13);
    check({31'h0, irq}, 32'h0);
    rd(`LIN_A_CTRL, rv);
    check(rv, cfg | (32'h1 << `LIN_C_HDF));
    rd(`LIN_A_STAT, rv);
    check(rv, 32'h3);
    rd(`LIN_A_DATA, rv);
    check(rv, 32'h0);
    cpu_mask <= 2'h0;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    wr(`LIN_A_CTRL, cfg);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    lin_node_inst.send_char(8'h55, 1'b1);
    rd(`LIN_A_STAT, rv);
    check(rv, 32'h3);
    rd(`LIN_A_DATA, rv);
    check(rv, 32'h55);
    // wrong synch value with resync off
    lin_node_inst.send_break(13);
    rd(`LIN_A_STAT, rv);
    rd(`LIN_A_DATA, rv);
    wr(`LIN_A_CTRL, cfg);
    lin_node_inst.send_char(8'h33, 1'b1);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h1);
    rd(`LIN_A_DATA, rv);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h0);
    // framing fault on data, none on a break
    lin_node_inst.send_char(8'hA5, 1'b0);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_FE]}, 32'h1);
    rd(`LIN_A_DATA, rv);
    lin_node_inst.send_break(13);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_FE]}, 32'h0);
    rd(`LIN_A_DATA, rv);
    // identifier method with parity, good then bad parity
    cfg = (32'h1 << `LIN_C_LINE) | (32'h1 << `LIN_C_SLV);
    cfg = cfg | (32'h1 << `LIN_C_HDM) | (32'h1 << `LIN_C_PCE);
    wr(`LIN_A_CTRL, cfg);
    for (int k = 0; k < 2; k++)
    begin
      idb = lin_id(6'h1A) ^ ((k == 1) ? 8'h80 : 8'h00);
      lin_node_inst.send_break(13);
      rd(`LIN_A_STAT, rv);
      check(rv, 32'h2);
      lin_node_inst.send_char(8'h55, 1'b1);
      rd(`LIN_A_STAT, rv);
      check(rv, 32'h2);
      lin_node_inst.send_char(idb, 1'b1);
      rd(`LIN_A_STAT, rv);
      check(rv, (k == 1) ? 32'h13 : 32'h3);
      rd(`LIN_A_DATA, rv);
      check(rv, {24'h0, idb});
      rd(`LIN_A_CTRL, rv);
      check(rv, cfg | (32'h1 << `LIN_C_HDF));
      wr(`LIN_A_CTRL, cfg);
    end
    // header that never completes: no error early, error after the limit
    lin_node_inst.send_break(13);
    waitb(40);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h0);
    waitb(22);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h1);
    check({31'h0, rv[`LIN_S_RX_DATA_FULL]}, 32'h0);
    rd(`LIN_A_HLEN, rv);
    check(rv, `LIN_HDR_BITS * `LIN_OVS);
    rd(`LIN_A_DATA, rv);
    // resync on: synch measured, not stored, divider reloaded from it
    cfg = (32'h1 << `LIN_C_LINE) | (32'h1 << `LIN_C_SLV) | (32'h1 << `LIN_C_ASE);
    wr(`LIN_A_CTRL, cfg);
    lin_node_inst.send_break(13);
    rd(`LIN_A_STAT, rv);
    rd(`LIN_A_DATA, rv);
    check(rv, 32'h0);
    lin_node_inst.send_char(8'h55, 1'b1);
    rd(`LIN_A_STAT, rv);
    check(rv, 32'h2);
    lin_node_inst.send_char(lin_id(6'h1A), 1'b1);
    rd(`LIN_A_STAT, rv);
    check(rv, 32'h3);
    rd(`LIN_A_DATA, rv);
    check(rv, {24'h0, lin_id(6'h1A)});
    rd(`LIN_A_MANT, rv);
    check(rv, 32'h4);
    rd(`LIN_A_FRAC, rv);
    check(rv, 32'h0);
    // divider of twice the bit time: synch edges come too fast, unit locks
    wr(`LIN_A_MANT, 32'h8);
    lin_node_inst.send_break(26);
    lin_node_inst.send_char(8'h55, 1'b1);
    waitb(24);
    rd(`LIN_A_CTRL, rv);
    check({31'h0, rv[`LIN_C_LSF]}, 32'h1);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h1);
    wr(`LIN_A_CTRL, cfg);
    rd(`LIN_A_DATA, rv);
    rd(`LIN_A_STAT, rv);
    check({31'h0, rv[`LIN_S_LHE]}, 32'h0);
    print_verdict();
  end
endmodule : lin_mode_serial_extension_tb_top
`default_nettype wire
